// ### sos_cfg.svh
/*
  Constants of the status output selector: register offsets, field positions,
  reset values and timing counts.
  Assumes the includer uses them with the types of sos_pkg.
*/
`ifndef SOS_CFG_SVH
`define SOS_CFG_SVH

// ****************************************************************
// register offsets (byte addresses, one word each)
// ****************************************************************
`define SOS_ADDR_W          8
`define SOS_REG_MODE        8'h00
`define SOS_REG_UPPER       8'h04
`define SOS_REG_LOWER       8'h08
`define SOS_REG_MAINT_IVL   8'h0c
`define SOS_REG_PID_LIMIT   8'h10
`define SOS_REG_STATUS      8'h14
`define SOS_REG_IRQ_STATUS  8'h18
`define SOS_REG_IRQ_MASK    8'h1c
`define SOS_REG_CONTROL     8'h20
`define SOS_REG_MAINT_CNT   8'h24

// ****************************************************************
// field positions
// ****************************************************************
`define SOS_STAT_OUT_BIT    0
`define SOS_STAT_DUE_BIT    1
`define SOS_STAT_HYST_LSB   4
`define SOS_STAT_MODE_LSB   8
`define SOS_IRQ_RISE_BIT    0
`define SOS_IRQ_FALL_BIT    1
`define SOS_IRQ_MAINT_BIT   2
`define SOS_CTRL_RESTART    0

// ****************************************************************
// reset values (thresholds in 0.1 percent units)
// ****************************************************************
`define SOS_MODE_RST        4'h0
`define SOS_UPPER_RST       16'h03e8
`define SOS_LOWER_RST       16'h03e8
`define SOS_THR_MAX         16'h07d0
`define SOS_MAINT_IVL_RST   32'h0000_0000
`define SOS_PID_LIMIT_RST   16'h0000
`define SOS_IRQ_MASK_RST    3'h0

// ****************************************************************
// timing
// ****************************************************************
`define SOS_CLK_NS          5
`define SOS_TICK_NS         1000000
`define SOS_TICK_CYCLES     (`SOS_TICK_NS / `SOS_CLK_NS)

// ****************************************************************
// bus answers
// ****************************************************************
`define SOS_RESP_OKAY       2'h0
`define SOS_RESP_SLVERR     2'h2

`endif

// ### sos_pkg.sv
/*
  Types of the status output selector: modes, bus states, carriers and the
  state records of its modules.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package sos_pkg;

  typedef enum logic [3:0] {
    MODE_RUNNING      = 4'b0000,
    MODE_HEALTHY      = 4'b0001,
    MODE_AT_TARGET    = 4'b0010,
    MODE_FREQ_NONZERO = 4'b0011,
    MODE_FREQ_LIMIT   = 4'b0100,
    MODE_CURR_LIMIT   = 4'b0101,
    MODE_TORQ_LIMIT   = 4'b0110,
    MODE_AIN2_LIMIT   = 4'b0111,
    MODE_RSVD8        = 4'b1000,
    MODE_RSVD9        = 4'b1001,
    MODE_MAINT_DUE    = 4'b1010,
    MODE_READY        = 4'b1011,
    MODE_TRIPPED      = 4'b1100,
    MODE_SAFE_TORQUE  = 4'b1101,
    MODE_PID_ERROR    = 4'b1110,
    MODE_HIGH_LOAD    = 4'b1111
  } sos_mode_type;

  typedef enum logic {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } sos_wr_type;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } sos_rd_type;

  // drive conditions from logic on core_clk
  typedef struct packed {
    logic running;
    logic faultPresent;
    logic atTarget;
    logic tripped;
    logic mainsPresent;
    logic operationPermitted;
    logic loadMonitorEnable;
    logic highLoad;
  } sos_flags_type;

  // terminal inputs, asynchronous to core_clk
  typedef struct packed {
    logic safeTorqueOffA;
    logic safeTorqueOffB;
    logic hwEnable;
  } sos_pins_type;

  // measured quantities, 0.1 percent units, normalised upstream
  typedef struct packed {
    logic [15:0] outputFreq;
    logic [15:0] motorCurrent;
    logic [15:0] motorTorque;
    logic [15:0] analogIn2;
    logic [15:0] pidSetpoint;
    logic [15:0] pidFeedback;
  } sos_quant_type;

  typedef struct packed {
    sos_pins_type stage1;
    sos_pins_type stage2;
  } sos_sync_state_type;

  typedef struct packed {
    logic above;
  } sos_hyst_state_type;

  typedef struct packed {
    sos_wr_type   wrState;
    sos_rd_type   rdState;
    logic         awPend;
    logic         wPend;
    logic [7:0]   awAddr;
    logic [31:0]  wData;
    logic [3:0]   wStrb;
    logic [1:0]   bResp;
    logic [31:0]  rData;
    logic [1:0]   rResp;
    sos_mode_type mode;
    logic [15:0]  upperThreshold;
    logic [15:0]  lowerThreshold;
    logic [31:0]  maintInterval;
    logic [15:0]  pidLimit;
    logic [2:0]   irqStatus;
    logic [2:0]   irqMask;
    logic [31:0]  tickCnt;
    logic [31:0]  maintCnt;
    logic         maintDue;
    logic         statusOut;
  } sos_state_type;

endpackage

`default_nettype wire

// ### sos_sync.sv
/*
  Two-stage synchroniser for the terminal inputs.
  Assumes the inputs are slow levels; a pulse shorter than one clock may be lost.
*/
`timescale 1ns/1ps
`default_nettype none

module sos_sync
  import sos_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire sos_pins_type pinsIn,
  output var  sos_pins_type pinsOut
);

  sos_sync_state_type s_q;
  sos_sync_state_type s_d;

  always_comb
  begin
    s_d        = s_q;
    s_d.stage1 = pinsIn;
    s_d.stage2 = s_q.stage1;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign pinsOut = s_q.stage2;

endmodule

`default_nettype wire

// ### sos_hyst.sv
/*
  Two-threshold comparator with hysteresis for one measured quantity.
  Assumes upper is not below lower, which the register logic guarantees.
*/
`timescale 1ns/1ps
`default_nettype none

module sos_hyst
  import sos_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] level,
  input  wire logic [15:0] upperThreshold,
  input  wire logic [15:0] lowerThreshold,
  output logic             above
);

  sos_hyst_state_type s_q;
  sos_hyst_state_type s_d;

  always_comb
  begin
    s_d = s_q;
    if (level >= upperThreshold)
      s_d.above = 1'b1; // RULE8
    else if (level < lowerThreshold)
      s_d.above = 1'b0; // RULE9
  end

  // state cleared in reset
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      s_q <= '0; // RULE18
    else
      s_q <= s_d;
  end

  assign above = s_q.above;

endmodule

`default_nettype wire

// ### sos_status_output_selector.sv
/*
  Status output selector of a variable speed drive: one digital output whose
  meaning is chosen by a mode register, with AXI4-Lite registers, a
  maintenance interval timer and a level interrupt.
  Assumes quantities arrive on core_clk already scaled to 0.1 percent units
  and the terminal inputs arrive asynchronous to core_clk.

// Function
// (RULE1) modes 0-2: running, healthy, at target
// (RULE2) output one means terminal sources 24 V
// (RULE3) mode 3: output frequency above zero
// (RULE4) mode 4: frequency hysteresis comparison
// (RULE5) mode 5: current hysteresis comparison
// (RULE6) mode 6: torque hysteresis comparison
// (RULE7) mode 7: analog input two comparison
// (RULE8) set output at upper threshold
// (RULE9) clear below lower, else hold
// (RULE10) modes 8, 9 hold output low
// (RULE11) mode 10: maintenance timer expired
// (RULE12) mode 11: ready, four conditions ANDed
// (RULE13) mode 12: drive tripped
// (RULE14) mode 13: both safe-off inputs, operation permitted
// (RULE15) mode 14: PID error at least limit
// (RULE16) mode 15: load monitor enabled and high load
// (RULE17) upper threshold from lower to 200.0 percent
// (RULE18) evaluate every cycle, cleared in reset
*/
`timescale 1ns/1ps
`default_nettype none
`include "sos_cfg.svh"

module sos_status_output_selector
  import sos_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `SOS_TICK_CYCLES
)
(
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  // axi4-lite slave
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  output logic [1:0]         s_axi_bresp,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  input  wire logic [7:0]    s_axi_araddr,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  // drive side
  input  wire sos_flags_type driveFlags,
  input  wire sos_pins_type  terminalPins,
  input  wire sos_quant_type quantities,
  // terminal and interrupt
  output logic               statusOut,
  output logic               irq
);

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic [31:0] applyStrb(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = data[8*i +: 8];
    end
    return res;
  endfunction

  function automatic logic [15:0] clampRange(
    input logic [15:0] val,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    logic [15:0] res;
    res = val;
    if (val < lo)
      res = lo;
    else if (val > hi)
      res = hi;
    return res;
  endfunction

  function automatic logic [15:0] absDiff(
    input logic [15:0] a,
    input logic [15:0] b
  );
    return (a >= b) ? (a - b) : (b - a);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  sos_state_type s_q;
  sos_state_type s_d;
  sos_pins_type  pinsSync;
  logic [3:0]    hystAbove;
  logic [15:0]   hystLevel [4];

  // ****************************************************************
  // terminal inputs and comparators
  // ****************************************************************
  sos_sync u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pinsIn   (terminalPins),
    .pinsOut  (pinsSync)
  );

  assign hystLevel[0] = quantities.outputFreq;
  assign hystLevel[1] = quantities.motorCurrent;
  assign hystLevel[2] = quantities.motorTorque;
  assign hystLevel[3] = quantities.analogIn2;

  // one comparator per quantity so each keeps its history across mode changes
  for (genvar g = 0; g < 4; g++)
  begin : gen_hyst
    sos_hyst u_hyst (
      .core_clk       (core_clk),
      .reset_n        (reset_n),
      .level          (hystLevel[g]),
      .upperThreshold (s_q.upperThreshold),
      .lowerThreshold (s_q.lowerThreshold),
      .above          (hystAbove[g])
    );
  end

  // ****************************************************************
  // condition select
  // ****************************************************************
  logic safeOffClosed;
  logic selected;

  assign safeOffClosed = pinsSync.safeTorqueOffA & pinsSync.safeTorqueOffB;

  always_comb
  begin
    selected = 1'b0;
    unique case (s_q.mode)
      MODE_RUNNING:      selected = driveFlags.running; // RULE1
      MODE_HEALTHY:      selected = !driveFlags.faultPresent; // RULE1
      MODE_AT_TARGET:    selected = driveFlags.atTarget; // RULE1
      MODE_FREQ_NONZERO: selected = (quantities.outputFreq != 16'h0000); // RULE3
      MODE_FREQ_LIMIT:   selected = hystAbove[0]; // RULE4
      MODE_CURR_LIMIT:   selected = hystAbove[1]; // RULE5
      MODE_TORQ_LIMIT:   selected = hystAbove[2]; // RULE6
      MODE_AIN2_LIMIT:   selected = hystAbove[3]; // RULE7
      MODE_RSVD8:        selected = 1'b0; // RULE10
      MODE_RSVD9:        selected = 1'b0; // RULE10
      MODE_MAINT_DUE:    selected = s_q.maintDue; // RULE11
      MODE_READY:        selected = !driveFlags.tripped & safeOffClosed
                                    & driveFlags.mainsPresent & pinsSync.hwEnable; // RULE12
      MODE_TRIPPED:      selected = driveFlags.tripped; // RULE13
      MODE_SAFE_TORQUE:  selected = safeOffClosed & driveFlags.operationPermitted; // RULE14
      MODE_PID_ERROR:    selected = absDiff(quantities.pidSetpoint, quantities.pidFeedback)
                                    >= s_q.pidLimit; // RULE15
      MODE_HIGH_LOAD:    selected = driveFlags.loadMonitorEnable & driveFlags.highLoad; // RULE16
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  logic        awTake;
  logic        wTake;
  logic        arTake;
  logic        doWrite;
  logic        tickPulse;
  logic        maintExpire;
  logic        restart;
  logic        addrHit;
  logic [31:0] wMerged;
  logic [2:0]  irqSet;
  logic [2:0]  irqClr;

  assign awTake  = s_axi_awvalid & s_axi_awready;
  assign wTake   = s_axi_wvalid & s_axi_wready;
  assign arTake  = s_axi_arvalid & s_axi_arready;
  assign doWrite = (s_q.wrState == WR_IDLE) & s_q.awPend & s_q.wPend;

  always_comb
  begin
    s_d         = s_q;
    restart     = 1'b0;
    addrHit     = 1'b1;
    irqClr      = 3'h0;
    wMerged     = 32'h0000_0000;
    tickPulse   = (s_q.tickCnt == 32'(TICK_CYCLES - 1));
    maintExpire = 1'b0;

    // write address and data, taken in either order
    if (awTake)
    begin
      s_d.awPend = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (wTake)
    begin
      s_d.wPend = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end

    if (doWrite)
    begin
      s_d.awPend  = 1'b0;
      s_d.wPend   = 1'b0;
      s_d.wrState = WR_RESP;
      unique case (s_q.awAddr)
        `SOS_REG_MODE:
        begin
          wMerged = applyStrb({28'h0000000, s_q.mode}, s_q.wData, s_q.wStrb);
          s_d.mode = sos_mode_type'(wMerged[3:0]);
        end
        `SOS_REG_UPPER:
        begin
          wMerged = applyStrb({16'h0000, s_q.upperThreshold}, s_q.wData, s_q.wStrb);
          s_d.upperThreshold = clampRange(wMerged[15:0], s_q.lowerThreshold, `SOS_THR_MAX); // RULE17
        end
        `SOS_REG_LOWER:
        begin
          wMerged = applyStrb({16'h0000, s_q.lowerThreshold}, s_q.wData, s_q.wStrb);
          // lower may never pass upper, keeping the hysteresis band sane
          s_d.lowerThreshold = clampRange(wMerged[15:0], 16'h0000, s_q.upperThreshold);
        end
        `SOS_REG_MAINT_IVL:
        begin
          s_d.maintInterval = applyStrb(s_q.maintInterval, s_q.wData, s_q.wStrb);
          restart = 1'b1;
        end
        `SOS_REG_PID_LIMIT:
        begin
          wMerged = applyStrb({16'h0000, s_q.pidLimit}, s_q.wData, s_q.wStrb);
          s_d.pidLimit = wMerged[15:0];
        end
        `SOS_REG_IRQ_STATUS:
        begin
          if (s_q.wStrb[0])
            irqClr = s_q.wData[2:0];
        end
        `SOS_REG_IRQ_MASK:
        begin
          if (s_q.wStrb[0])
            s_d.irqMask = s_q.wData[2:0];
        end
        `SOS_REG_CONTROL:
        begin
          if (s_q.wStrb[0])
            restart = s_q.wData[`SOS_CTRL_RESTART];
        end
        `SOS_REG_STATUS, `SOS_REG_MAINT_CNT:
          addrHit = 1'b1;
        default:
          addrHit = 1'b0;
      endcase
      s_d.bResp = addrHit ? `SOS_RESP_OKAY : `SOS_RESP_SLVERR;
    end
    else if ((s_q.wrState == WR_RESP) && s_axi_bready)
    begin
      s_d.wrState = WR_IDLE;
    end

    // read channel
    if (arTake)
    begin
      s_d.rdState = RD_DATA;
      s_d.rResp   = `SOS_RESP_OKAY;
      s_d.rData   = 32'h0000_0000;
      unique case (s_axi_araddr)
        `SOS_REG_MODE:       s_d.rData = {28'h0000000, s_q.mode};
        `SOS_REG_UPPER:      s_d.rData = {16'h0000, s_q.upperThreshold};
        `SOS_REG_LOWER:      s_d.rData = {16'h0000, s_q.lowerThreshold};
        `SOS_REG_MAINT_IVL:  s_d.rData = s_q.maintInterval;
        `SOS_REG_PID_LIMIT:  s_d.rData = {16'h0000, s_q.pidLimit};
        `SOS_REG_STATUS:
        begin
          s_d.rData[`SOS_STAT_OUT_BIT]                    = s_q.statusOut;
          s_d.rData[`SOS_STAT_DUE_BIT]                    = s_q.maintDue;
          s_d.rData[`SOS_STAT_HYST_LSB +: 4]              = hystAbove;
          s_d.rData[`SOS_STAT_MODE_LSB +: 4]              = s_q.mode;
        end
        `SOS_REG_IRQ_STATUS: s_d.rData = {29'h00000000, s_q.irqStatus};
        `SOS_REG_IRQ_MASK:   s_d.rData = {29'h00000000, s_q.irqMask};
        `SOS_REG_CONTROL:    s_d.rData = 32'h0000_0000;
        `SOS_REG_MAINT_CNT:  s_d.rData = s_q.maintCnt;
        default:             s_d.rResp = `SOS_RESP_SLVERR;
      endcase
    end
    else if ((s_q.rdState == RD_DATA) && s_axi_rready)
    begin
      s_d.rdState = RD_IDLE;
    end

    // maintenance timer, counts 1 ms ticks; interval zero disables it
    s_d.tickCnt = tickPulse ? 32'h0000_0000 : s_q.tickCnt + 32'h0000_0001;
    if (restart)
    begin
      s_d.maintCnt = 32'h0000_0000;
      s_d.maintDue = 1'b0;
    end
    else if (tickPulse && (s_q.maintInterval != 32'h0000_0000) && !s_q.maintDue)
    begin
      s_d.maintCnt = s_q.maintCnt + 32'h0000_0001;
      if (s_d.maintCnt >= s_q.maintInterval)
      begin
        s_d.maintDue = 1'b1; // RULE11
        maintExpire  = 1'b1;
      end
    end

    // output re-evaluated every cycle
    s_d.statusOut = selected; // RULE18

    // sticky events, set wins over a clear in the same cycle
    irqSet                    = 3'h0;
    irqSet[`SOS_IRQ_RISE_BIT]  = selected & !s_q.statusOut;
    irqSet[`SOS_IRQ_FALL_BIT]  = !selected & s_q.statusOut;
    irqSet[`SOS_IRQ_MAINT_BIT] = maintExpire;
    s_d.irqStatus = (s_q.irqStatus & ~irqClr) | irqSet;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q                <= '0; // RULE18
      s_q.mode           <= sos_mode_type'(`SOS_MODE_RST);
      s_q.upperThreshold <= `SOS_UPPER_RST; // RULE17
      s_q.lowerThreshold <= `SOS_LOWER_RST;
      s_q.maintInterval  <= `SOS_MAINT_IVL_RST;
      s_q.pidLimit       <= `SOS_PID_LIMIT_RST;
      s_q.irqMask        <= `SOS_IRQ_MASK_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign s_axi_awready = (s_q.wrState == WR_IDLE) & !s_q.awPend;
  assign s_axi_wready  = (s_q.wrState == WR_IDLE) & !s_q.wPend;
  assign s_axi_bvalid  = (s_q.wrState == WR_RESP);
  assign s_axi_bresp   = s_q.bResp;
  assign s_axi_arready = (s_q.rdState == RD_IDLE);
  assign s_axi_rvalid  = (s_q.rdState == RD_DATA);
  assign s_axi_rdata   = s_q.rData;
  assign s_axi_rresp   = s_q.rResp;

  // logic one drives the terminal to +24 V through the output stage
  assign statusOut = s_q.statusOut; // RULE2
  assign irq       = |(s_q.irqStatus & s_q.irqMask);

endmodule

`default_nettype wire

// ### sos_checker.sv
/*
  Port checker of the status output selector.
  Assumes each bus write offers address and data together.
*/
`timescale 1ns/1ps
`default_nettype none
module sos_checker
  import sos_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 4
)
(
  input wire logic          core_clk,
  input wire logic          reset_n,
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic [7:0]    s_axi_awaddr,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic [31:0]   s_axi_wdata,
  input wire sos_flags_type driveFlags,
  input wire sos_quant_type quantities,
  input wire logic          statusOut,
  input wire logic          irq
);
  // shadow mode; ok waits out the write latency so mode changes never race
  logic [3:0] md_q;
  logic [3:0] pd_q;
  logic       p_q;
  logic [1:0] st_q;
  logic       ok;
  assign ok = st_q == 2'h3;
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      md_q <= 4'h0;
      pd_q <= 4'h0;
      p_q  <= 1'b0;
      st_q <= 2'h0;
    end
    else
    begin
      p_q  <= s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & (s_axi_awaddr == 8'h00);
      pd_q <= s_axi_wdata[3:0];
      md_q <= p_q ? pd_q : md_q;
      // a threshold write may legally move the output, so it restarts the wait too
      st_q <= (p_q | (s_axi_awvalid & s_axi_awready & (s_axi_awaddr inside {8'h04, 8'h08}))) ? 2'h0
              : st_q + {1'b0, !ok};
    end
  // ********
  // properties
  // ********
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence steady;
    $stable(quantities) [*3];
  endsequence
  AST_RUN: assert property (ok && md_q == 4'h0 |=> statusOut == $past(driveFlags.running))
    else $error("mode 0 output wrong");
  AST_HEALTHY: assert property (ok && md_q == 4'h1 |=> statusOut == !$past(driveFlags.faultPresent))
    else $error("mode 1 output wrong");
  AST_MOVING: assert property (ok && md_q == 4'h3 |=> statusOut == ($past(quantities.outputFreq) != 16'h0))
    else $error("mode 3 output wrong");
  AST_HOLD: assert property (steady ##0 (ok && md_q inside {[4'h4:4'h7]}) |=> $stable(statusOut))
    else $error("threshold output moved");
  AST_RSVD: assert property (ok && md_q[3:1] == 3'h4 |=> !statusOut)
    else $error("reserved mode output high");
  AST_TRIP: assert property (ok && md_q == 4'hc |=> statusOut == $past(driveFlags.tripped))
    else $error("mode 12 output wrong");
  AST_LOAD: assert property (ok && md_q == 4'hf |=> statusOut == $past(driveFlags.loadMonitorEnable & driveFlags.highLoad))
    else $error("mode 15 output wrong");
  AST_RST: assert property ($rose(reset_n) |-> !statusOut && !irq)
    else $error("outputs high after reset");
endmodule
bind sos_status_output_selector sos_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (.*);
`default_nettype wire

// ### sos_term_model.sv
/*
  Load on the status terminal: shows the volts it sees.
  Assumes the terminal sources 24 V while the output is high.
*/
`timescale 1ns/1ps
`default_nettype none
module sos_term_model (
  input  wire logic  statusOut,
  output logic [4:0] termVolts
);
  assign termVolts = statusOut ? 5'h18 : 5'h00;
endmodule
`default_nettype wire

// ### tb_top.sv
/*
  Bench of the status output selector with a terminal load.
  Assumes the design, checker and load model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sos_pkg::*;
  logic core_clk, reset_n, statusOut, irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]    s_axi_awaddr, s_axi_araddr;
  logic [31:0]   s_axi_wdata, s_axi_rdata;
  logic [3:0]    s_axi_wstrb;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic [4:0]    termVolts;
  sos_flags_type driveFlags;
  sos_pins_type  terminalPins;
  sos_quant_type quantities;
  int            n_fail, cmp_count, cyc;
  // mode list and, per mode, the expected output for vectors 3..0
  logic [3:0]    ml [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
  logic [3:0]    ex [11] = '{4'h5, 4'h6, 4'h5, 4'hd, 4'h0, 4'h0, 4'h4, 4'h9, 4'h9, 4'h9, 4'h1};
  sos_flags_type fv [4] = '{8'hff, 8'h00, 8'ha9, 8'h56};
  sos_pins_type  pv [4] = '{3'h7, 3'h0, 3'h7, 3'h6};
  logic [15:0]   fq [4] = '{16'h5, 16'h0, 16'h1, 16'h2};
  logic [15:0]   pq [4] = '{16'h64, 16'h0, 16'h63, 16'hffff};
  logic [15:0]   lv [6] = '{16'h5db, 16'h5dc, 16'h3e8, 16'h1f4, 16'h1f3, 16'h3e8};
  logic          ev [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  sos_status_output_selector #(.TICK_CYCLES(4)) uut (.*);
  sos_term_model load (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      report_and_stop;
    end
  end

  // ********
  // bus and compare
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    // bready stays high: no task lowers it, and each later wr call sets it again
    while (!s_axi_bvalid);
    chk(s_axi_bresp, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_regs;
    rd(8'h04, 32'h3e8, 2'h0);
    wr(8'h04, 32'h900, 2'h0);
    rd(8'h04, 32'h7d0, 2'h0);
    wr(8'h04, 32'h100, 2'h0);
    rd(8'h04, 32'h3e8, 2'h0);
    wr(8'h40, 32'h1, 2'h2);
    rd(8'h40, 32'h0, 2'h2);
    wr(8'h10, 32'h64, 2'h0);
    $display("end regs");
  endtask

  task automatic t_modes;
    for (int i = 0; i < 11; i++)
    begin
      wr(8'h00, 32'(ml[i]), 2'h0);
      for (int v = 0; v < 4; v++)
      begin
        driveFlags <= fv[v];
        terminalPins <= pv[v];
        quantities <= {fq[v], 48'h0, pq[v], 16'h0};
        repeat (5) @(posedge core_clk);
        chk(statusOut, ex[i][v]);
        chk(termVolts, ex[i][v] ? 32'h18 : 32'h0);
      end
    end
    $display("end modes");
  endtask

  task automatic t_hyst;
    wr(8'h08, 32'h1f4, 2'h0);
    wr(8'h04, 32'h5dc, 2'h0);
    for (int m = 4; m < 8; m++)
    begin
      quantities <= '0;
      wr(8'h00, 32'(m), 2'h0);
      for (int k = 0; k < 6; k++)
      begin
        // only the selected quantity moves, so a wrong pick stays low
        quantities <= 96'(lv[k]) << (32 + 16 * (7 - m));
        repeat (4) @(posedge core_clk);
        chk(statusOut, ev[k]);
      end
    end
    $display("end hyst");
  endtask

  task automatic t_irq;
    driveFlags <= 8'h00;
    wr(8'h00, 32'h0, 2'h0);
    wr(8'h18, 32'h7, 2'h0);
    driveFlags <= 8'h80;
    repeat (3) @(posedge core_clk);
    chk(irq, 1'b0);
    wr(8'h1c, 32'h1, 2'h0);
    chk(irq, 1'b1);
    rd(8'h18, 32'h1, 2'h0);
    wr(8'h18, 32'h1, 2'h0);
    chk(irq, 1'b0);
    driveFlags <= 8'h00;
    repeat (3) @(posedge core_clk);
    rd(8'h18, 32'h2, 2'h0);
    chk(irq, 1'b0);
    $display("end irq");
  endtask

  task automatic t_maint;
    wr(8'h00, 32'ha, 2'h0);
    wr(8'h0c, 32'h3, 2'h0);
    chk(statusOut, 1'b0);
    repeat (24) @(posedge core_clk);
    chk(statusOut, 1'b1);
    rd(8'h18, 32'h7, 2'h0);
    wr(8'h20, 32'h1, 2'h0);
    repeat (2) @(posedge core_clk);
    chk(statusOut, 1'b0);
    $display("end maint");
  endtask

  task automatic t_reset;
    driveFlags <= 8'hff;
    wr(8'h00, 32'hc, 2'h0);
    repeat (2) @(posedge core_clk);
    chk(statusOut, 1'b1);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(statusOut, 1'b0);
    reset_n <= 1'b1;
    rd(8'h00, 32'h0, 2'h0);
    repeat (2) @(posedge core_clk);
    chk(statusOut, 1'b1);
    $display("end reset");
  endtask

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr,
     s_axi_araddr, s_axi_wdata, s_axi_wstrb, driveFlags, terminalPins, quantities} = '0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs;
    t_modes;
    t_hyst;
    t_irq;
    t_maint;
    t_reset;
    report_and_stop;
  end
endmodule
`default_nettype wire
